// >>> src/ebmc_top.sv
// External bus mode control: mode select, address output and area two multiplexing
`timescale 1ns/10ps
module ebmc_top #(
	parameter logic [23:0] SFR_END    = 24'h00007F,  // Special function registers top
	parameter logic [23:0] RAM_BASE   = 24'h000080,  // Internal RAM base
	parameter logic [23:0] RAM_END    = 24'h000FFF,  // Internal RAM top
	parameter logic [23:0] ROM_BASE   = 24'h008000,  // Internal ROM base
	parameter logic [23:0] ROM_END    = 24'h01FFFF,  // Internal ROM top
	parameter logic [23:0] AREA2_BASE = 24'h200000,  // Area two base
	parameter logic [23:0] AREA2_END  = 24'h2FFFFF   // Area two top
) (
	// Clock and reset
	input  wire logic               pclk,
	input  wire logic               presetn,
	// APB slave
	input  wire logic [11:0]        paddr,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	// Mode strap pin
	input  wire logic               mode_select_pin,
	// CPU access port
	input  wire logic               cpu_req_valid,
	output logic                    cpu_req_ready,
	input  wire ebmc_pkg::ebmc_req_t cpu_req,
	output logic                    cpu_done,
	output logic                    cpu_fault,
	output logic      [15:0]        cpu_rdata,
	// Internal resources
	output logic      [2:0]         int_sel,
	input  wire logic [15:0]        int_rdata,
	// External pins
	output ebmc_pkg::ebmc_pins_t    pins,
	input  wire logic [7:0]         low_data_lines_i,
	output logic                    port_bus_mode
);
	import ebmc_pkg::*;

	// ************************************************************
	// Elaboration check
	// ************************************************************
	if (RAM_BASE > RAM_END || ROM_BASE > ROM_END || AREA2_BASE > AREA2_END || PHI_CYC < 2 || DATA_CYC > 8) begin : g_bad
		$error("ebmc_top: address ranges or phase count unusable");
	end

	// ************************************************************
	// Address decode functions
	// ************************************************************
	// Range hit, used for every area except the SFR block
	function automatic logic in_range(input logic [23:0] a, input logic [23:0] lo, input logic [23:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction : in_range

	// APB index match
	function automatic logic idx_hit(input logic [11:0] a, input logic [7:0] idx);
		idx_hit = (a == {2'h0, idx, 2'h0});
	endfunction : idx_hit

	// ************************************************************
	// Mode strap synchroniser
	// ************************************************************
	logic [2:0] md_sync_q;   // Three stage strap sampler
	logic       md_level_q;  // Accepted strap level

	// Shift the strap through three flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			md_sync_q <= 3'h0;
		end else begin
			md_sync_q <= {md_sync_q[1:0], mode_select_pin};
		end
	end

	// Accept a change only once stages two and three agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			md_level_q <= 1'b0;
		end else if (md_sync_q[1] == md_sync_q[2]) begin
			md_level_q <= md_sync_q[2];
		end
	end

	// ************************************************************
	// APB register file
	// ************************************************************
	logic [1:0] mode_bits_q;   // Processor mode bits
	logic [1:0] mode_bits_d;
	logic       addr_sel_q;    // Address output select
	logic       mux_sel_q;     // Multiplexed bus select
	logic       width8_q;      // Area two is 8 bits wide
	logic       busy_q;        // Bus cycle running

	wire apb_wr      = psel && penable && pwrite;
	wire hit_mode    = idx_hit(paddr, IDX_PROC_MODE0);
	wire hit_fsel    = idx_hit(paddr, IDX_FUNC_SEL1);
	wire hit_a2h     = idx_hit(paddr, IDX_AREA2_CTRL_H);
	wire hit_width   = idx_hit(paddr, IDX_AREA2_WIDTH);
	wire hit_status  = idx_hit(paddr, IDX_STATUS);
	wire hit_any     = hit_mode || hit_fsel || hit_a2h || hit_width || hit_status;

	// Strap high pins the mode bits at 10; otherwise software owns them
	assign mode_bits_d = md_level_q ? MODE_MICRO :
	                     (apb_wr && hit_mode) ? pwdata[POS_MODE_LO +: 2] :
	                     mode_bits_q;

	// Control registers, reset into single-chip
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_bits_q <= RST_MODE_BITS;
			addr_sel_q  <= 1'b0;
			mux_sel_q   <= 1'b0;
			width8_q    <= 1'b0;
		end else begin
			mode_bits_q <= mode_bits_d;
			if (apb_wr && hit_fsel) begin
				addr_sel_q <= pwdata[POS_ADDR_SEL];
			end
			if (apb_wr && hit_a2h) begin
				mux_sel_q <= pwdata[POS_MUX_SEL];
			end
			if (apb_wr && hit_width) begin
				width8_q <= pwdata[POS_WIDTH8];
			end
		end
	end

	// Read mux; reserved bits read zero
	always_comb begin
		prdata = 32'h0000_0000;
		if (hit_mode) begin
			prdata[POS_MODE_LO +: 2] = mode_bits_q;
		end
		if (hit_fsel) begin
			prdata[POS_ADDR_SEL] = addr_sel_q;
		end
		if (hit_a2h) begin
			prdata[POS_MUX_SEL] = mux_sel_q;
		end
		if (hit_width) begin
			prdata[POS_WIDTH8] = width8_q;
		end
		if (hit_status) begin
			prdata[1:0] = mode_bits_q;
			prdata[2]   = md_level_q;
			prdata[3]   = busy_q;
		end
	end

	// Zero wait state, error on unmapped address
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !hit_any;

	// ************************************************************
	// Processor mode decode
	// ************************************************************
	ebmc_mode_t mode;  // Current processor mode

	// Decode mode bits; code 11 falls back to single-chip
	always_comb begin
		unique case (mode_bits_q)
			MODE_EXPAND: mode = EBMC_EXPAND;
			MODE_MICRO:  mode = EBMC_MICRO;
			default:     mode = EBMC_SINGLE;
		endcase
	end

	wire bus_mode = (mode != EBMC_SINGLE);

	// Ports serve as bus pins only in the expansion modes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_bus_mode <= 1'b0;
		end else begin
			port_bus_mode <= bus_mode;
		end
	end

	// ************************************************************
	// Access classification
	// ************************************************************
	wire [23:0] ra        = cpu_req.addr;
	wire        hit_sfr   = (ra <= SFR_END);
	wire        hit_ram   = in_range(ra, RAM_BASE, RAM_END);
	wire        hit_rom   = in_range(ra, ROM_BASE, ROM_END) && (mode != EBMC_MICRO);
	wire        hit_int   = hit_sfr || hit_ram || hit_rom;
	// Internal wins over any overlapping external device
	wire        go_ext    = !hit_int && bus_mode;
	wire        refuse    = !hit_int && !bus_mode;
	wire        hit_area2 = in_range(ra, AREA2_BASE, AREA2_END);
	wire        go_mux    = go_ext && hit_area2 && width8_q && mux_sel_q;

	// ************************************************************
	// Bus cycle sequencer
	// ************************************************************
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_INT,
		ST_DELAY,
		ST_ADDR,
		ST_DATA
	} ebmc_state_t;

	ebmc_state_t state_q;  // Sequencer state
	ebmc_state_t state_d;
	logic [2:0]  cnt_q;    // Cycles left in a phase
	logic [2:0]  cnt_d;
	ebmc_req_t   req_q;    // Accepted request
	logic        mux_q;    // Accepted access is multiplexed
	logic        int_q;    // Accepted access is internal
	logic [2:0]  sel_q;    // Internal target one-hot
	logic [7:0]  din_q1;   // Data line sampler stage one
	logic [7:0]  din_q2;   // Data line sampler stage two
	logic [7:0]  din_q3;   // Data line sampler stage three

	wire accept   = cpu_req_valid && (state_q == ST_IDLE);
	wire cnt_done = (cnt_q == 3'h0);
	assign cpu_req_ready = (state_q == ST_IDLE);
	assign busy_q        = (state_q != ST_IDLE);

	// Next state and phase counter
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_done ? 3'h0 : cnt_q - 3'h1;
		unique case (state_q)
			ST_IDLE: begin
				if (accept && !refuse) begin
					if (!go_ext) begin
						state_d = ST_INT;
						cnt_d   = 3'(PHI_CYC - 1);
					end else if (addr_sel_q) begin
						// Address start slips by half a phase
						state_d = ST_DELAY;
						cnt_d   = 3'(HALF_PHI_CYC - 1);
					end else begin
						state_d = ST_ADDR;
						cnt_d   = 3'(PHI_CYC - 1);
					end
				end
			end
			ST_INT: begin
				if (cnt_done) begin
					state_d = ST_IDLE;
				end
			end
			ST_DELAY: begin
				if (cnt_done) begin
					state_d = ST_ADDR;
					cnt_d   = 3'(PHI_CYC - 1);
				end
			end
			ST_ADDR: begin
				if (cnt_done) begin
					state_d = ST_DATA;
					cnt_d   = 3'(DATA_CYC - 1);
				end
			end
			ST_DATA: begin
				if (cnt_done) begin
					state_d = ST_IDLE;
				end
			end
		endcase
	end

	// Sequencer registers and request capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_IDLE;
			cnt_q   <= 3'h0;
			req_q   <= '0;
			mux_q   <= 1'b0;
			int_q   <= 1'b0;
			sel_q   <= 3'h0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			if (accept) begin
				req_q <= cpu_req;
				mux_q <= go_mux;
				int_q <= !go_ext;
				sel_q <= {hit_rom, hit_ram && !hit_sfr, hit_sfr};
			end
		end
	end

	// Sample the external data lines through three flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			din_q1 <= 8'h00;
			din_q2 <= 8'h00;
			din_q3 <= 8'h00;
		end else begin
			din_q1 <= low_data_lines_i;
			din_q2 <= din_q1;
			din_q3 <= din_q2;
		end
	end

	// ************************************************************
	// Pin drive
	// ************************************************************
	wire in_int  = (state_q == ST_INT);
	wire in_addr = (state_q == ST_ADDR);
	wire in_data = (state_q == ST_DATA);

	// Pins; strobes only for external cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pins <= '{addr: 24'h000000, addr_oe_n: 1'b1, data: 8'h00, data_oe_n: 1'b1,
			          ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1, area_two_n: 1'b1};
		end else begin
			pins.addr_oe_n <= !bus_mode;
			// Normal mode drives every address at once, select mode only external ones
			if (accept && !refuse && !addr_sel_q && bus_mode) begin
				pins.addr <= cpu_req.addr;
			end else if (state_q == ST_DELAY && cnt_done) begin
				pins.addr <= req_q.addr;
			end
			// Internal cycles under select mode leave pins.addr untouched
			pins.ale        <= in_addr && mux_q && !cnt_done;
			pins.area_two_n <= !(in_addr || (in_data && !cnt_done)) ||
			                   !in_range(req_q.addr, AREA2_BASE, AREA2_END);
			// Read strobe opens on the last address cycle so the three-flop data sampler sees it in time
			pins.rd_n       <= !(((in_addr && cnt_done) || (in_data && !cnt_done)) && !req_q.wr);
			pins.wr_n       <= !(in_data && !cnt_done && req_q.wr);
			// Mux: low address first, then low data byte on the same lines
			if (in_addr && !cnt_done && mux_q) begin
				pins.data      <= req_q.addr[7:0];
				pins.data_oe_n <= 1'b0;
			end else if (in_data && !cnt_done && req_q.wr) begin
				pins.data      <= req_q.wdata[7:0];
				pins.data_oe_n <= 1'b0;
			end else begin
				pins.data_oe_n <= 1'b1;
			end
		end
	end

	// ************************************************************
	// CPU answer
	// ************************************************************
	// Completion, fault and read data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_done  <= 1'b0;
			cpu_fault <= 1'b0;
			cpu_rdata <= 16'h0000;
			int_sel   <= 3'h0;
		end else begin
			cpu_done  <= (accept && refuse) || ((in_int || in_data) && cnt_done);
			cpu_fault <= accept && refuse;
			int_sel   <= (accept && !go_ext && !refuse) ? {hit_rom, hit_ram && !hit_sfr, hit_sfr} :
			             (in_int && !cnt_done) ? sel_q : 3'h0;
			if (in_int && cnt_done) begin
				cpu_rdata <= int_rdata;
			end else if (in_data && cnt_done && !req_q.wr) begin
				cpu_rdata <= {8'h00, din_q3};
			end
		end
	end

endmodule : ebmc_top

// >>> common/ebmc_pkg.sv
// Constants, types and register layout of the external bus mode controller
package ebmc_pkg;

	// ************************************************************
	// Register indices (byte address is four times the index)
	// ************************************************************
	localparam logic [7:0]  IDX_PROC_MODE0   = 8'h5E;  // Processor mode register
	localparam logic [7:0]  IDX_FUNC_SEL1    = 8'h63;  // Particular function select register
	localparam logic [7:0]  IDX_AREA2_CTRL_H = 8'h85;  // Area two control register high
	localparam logic [7:0]  IDX_AREA2_WIDTH  = 8'h90;  // Area two data width control
	localparam logic [7:0]  IDX_STATUS       = 8'h91;  // Block status, read only

	// ************************************************************
	// Field positions and reset values
	// ************************************************************
	localparam int          POS_MODE_LO      = 0;      // Processor mode bits 1:0
	localparam int          POS_ADDR_SEL     = 4;      // Address output select bit
	localparam int          POS_MUX_SEL      = 5;      // Multiplexed bus select bit
	localparam int          POS_WIDTH8       = 0;      // Area two 8-bit width bit
	localparam logic [1:0]  RST_MODE_BITS    = 2'h0;   // Mode bits after reset
	localparam logic [1:0]  MODE_SINGLE      = 2'h0;   // Single-chip code
	localparam logic [1:0]  MODE_EXPAND      = 2'h1;   // Memory expansion code
	localparam logic [1:0]  MODE_MICRO       = 2'h2;   // Microprocessor code

	// ************************************************************
	// Timing counts in pclk cycles
	// ************************************************************
	localparam int          PHI_CYC          = 2;      // One phase clock period
	localparam int          HALF_PHI_CYC     = PHI_CYC / 2;  // Half phase delay
	localparam int          DATA_CYC         = 2 * PHI_CYC;  // Strobe phase length

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [1:0] {
		EBMC_SINGLE,
		EBMC_EXPAND,
		EBMC_MICRO
	} ebmc_mode_t;

	typedef struct packed {
		logic [23:0] addr;   // Access address
		logic        wr;     // High for write
		logic [15:0] wdata;  // Write data
	} ebmc_req_t;

	typedef struct packed {
		logic [23:0] addr;        // Address pin levels
		logic        addr_oe_n;   // Address pins enable, low drives
		logic [7:0]  data;        // Low data lines out
		logic        data_oe_n;   // Low data lines enable, low drives
		logic        ale;         // Address latch strobe, mux phase
		logic        rd_n;        // Read strobe, active low
		logic        wr_n;        // Write strobe, active low
		logic        area_two_n;  // Area two select, active low
	} ebmc_pins_t;

endpackage : ebmc_pkg

// >>> testbench/ebmc_props.sv
// Port checker for the external bus mode controller
`timescale 1ns/10ps
module ebmc_props (
	// Clock, reset and APB
	input wire logic                 pclk,
	input wire logic                 presetn,
	input wire logic [11:0]          paddr,
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic                 pwrite,
	input wire logic [31:0]          pwdata,
	input wire logic                 pready,
	// Strap, CPU port and pins
	input wire logic                 mode_select_pin,
	input wire logic                 cpu_req_valid,
	input wire logic                 cpu_req_ready,
	input wire ebmc_pkg::ebmc_req_t  cpu_req,
	input wire logic                 cpu_done,
	input wire logic                 cpu_fault,
	input wire logic [2:0]           int_sel,
	input wire ebmc_pkg::ebmc_pins_t pins,
	input wire logic                 port_bus_mode
);
	import ebmc_pkg::*;
	// ************************************************************
	// Shadow registers
	// ************************************************************
	logic       sel_q;   // Address output select
	logic [1:0] mode_q;  // Last written mode code
	wire        wr_hit   = psel && penable && pready && pwrite;
	wire        hit_sel  = wr_hit && paddr == {2'h0, IDX_FUNC_SEL1, 2'h0};
	wire        hit_mode = wr_hit && paddr == {2'h0, IDX_PROC_MODE0, 2'h0};
	wire        accept   = cpu_req_valid && cpu_req_ready;
	wire        area2    = cpu_req.addr[23:20] == 4'h2;
	// Track the two control fields that the properties depend on
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_q  <= 1'b0;
			mode_q <= 2'h0;
		end else begin
			sel_q  <= hit_sel ? pwdata[POS_ADDR_SEL] : sel_q;
			mode_q <= hit_mode ? pwdata[1:0] : mode_q;
		end
	end
	// ************************************************************
	// Properties
	// ************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence strobe_fall;
		$fell(pins.rd_n) || $fell(pins.wr_n);
	endsequence
	sequence late_addr;
		$stable(pins.addr) ##1 pins.addr == $past(cpu_req.addr, 2);
	endsequence
	bus_oe_a: assert property (!pins.addr_oe_n |-> port_bus_mode)
		else $error("address pins driven in single-chip mode");
	ext_strobe_a: assert property ($fell(pins.rd_n) |-> port_bus_mode)
		else $error("read strobe in single-chip mode");
	fault_mode_a: assert property (accept && !port_bus_mode && area2 |-> ##[1:2] (cpu_done && cpu_fault))
		else $error("external access not refused");
	addr_hold_a: assert property (sel_q && |int_sel |-> $stable(pins.addr))
		else $error("address moved during internal access");
	addr_norm_a: assert property (accept && !sel_q && port_bus_mode |=> pins.addr == $past(cpu_req.addr))
		else $error("address not driven in normal mode");
	addr_late_a: assert property (accept && sel_q && area2 && port_bus_mode |=> late_addr)
		else $error("selected address timing wrong");
	mux_addr_a: assert property (pins.ale |-> !pins.data_oe_n && pins.data == pins.addr[7:0])
		else $error("muxed address phase wrong");
	mux_order_a: assert property ($rose(pins.ale) |-> ##[1:4] strobe_fall)
		else $error("no data phase after address phase");
	mux_mode_a: assert property (pins.ale |-> port_bus_mode && pins.addr[23:20] == 4'h2)
		else $error("muxed cycle outside expansion mode");
	overlap_a: assert property (|int_sel |-> pins.rd_n && pins.wr_n)
		else $error("external strobe on internal access");
	rom_gone_a: assert property (int_sel[2] |-> mode_q != MODE_MICRO)
		else $error("internal ROM reached in microprocessor mode");
	mode_map_a: assert property (hit_mode && !mode_select_pin && pwdata[1:0] inside {2'h1, 2'h2}
		|-> ##[1:2] port_bus_mode)
		else $error("mode code did not select bus mode");
	strap_a: assert property (mode_select_pin [*8] |-> port_bus_mode)
		else $error("strap high did not force microprocessor mode");
endmodule : ebmc_props
bind ebmc_top ebmc_props ebmc_props_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .mode_select_pin(mode_select_pin),
	.cpu_req_valid(cpu_req_valid), .cpu_req_ready(cpu_req_ready), .cpu_req(cpu_req), .cpu_done(cpu_done),
	.cpu_fault(cpu_fault), .int_sel(int_sel), .pins(pins), .port_bus_mode(port_bus_mode));

// >>> testbench/ebmc_ext_mem.sv
// External memory model answering reads on the device bus
`timescale 1ns/10ps
module ebmc_ext_mem (
	// Clock
	input  wire logic                 pclk,
	// Device pins
	input  wire ebmc_pkg::ebmc_pins_t pins,
	output logic [7:0]                low_data_lines_i
);
	import ebmc_pkg::*;
	logic [7:0] lat_q  = 8'h00;  // Low address taken from the muxed lines
	logic       mux_q  = 1'b0;   // Current cycle is multiplexed
	logic       rd_q   = 1'b1;   // Read strobe one cycle ago
	logic [7:0] last_q = 8'h00;  // Last level on the data lines
	wire  [7:0] adr    = mux_q ? lat_q : pins.addr[7:0];
	// Drive while read strobe is low; released lines toggle so no stale value survives
	assign low_data_lines_i = !pins.rd_n ? adr ^ 8'h5A : ~last_q;
	// Capture muxed address; the mux flag clears when the read strobe ends
	always @(posedge pclk) begin
		lat_q  <= pins.ale ? pins.data : lat_q;
		mux_q  <= pins.ale | (mux_q & !(!rd_q && pins.rd_n));
		rd_q   <= pins.rd_n;
		last_q <= low_data_lines_i;
	end
endmodule : ebmc_ext_mem

// >>> testbench/testbench.sv
// Self-checking bench for the external bus mode controller
`timescale 1ns/10ps
module testbench;
	import ebmc_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, mode_select_pin;
	logic        cpu_req_valid, cpu_req_ready, cpu_done, cpu_fault, port_bus_mode, seen_rd, seen_ale, seen_a2;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [15:0] cpu_rdata, int_rdata, rnd;
	logic [2:0]  int_sel, seen_int;
	logic [7:0]  low_data_lines_i;
	ebmc_req_t   cpu_req;
	ebmc_pins_t  pins;
	logic [33:0] notes[$];  // Expected results, oldest first
	int          fails, total_checks, n;
	ebmc_top ebmc_top_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.mode_select_pin(mode_select_pin), .cpu_req_valid(cpu_req_valid), .cpu_req_ready(cpu_req_ready),
		.cpu_req(cpu_req), .cpu_done(cpu_done), .cpu_fault(cpu_fault), .cpu_rdata(cpu_rdata),
		.int_sel(int_sel), .int_rdata(int_rdata), .pins(pins), .low_data_lines_i(low_data_lines_i),
		.port_bus_mode(port_bus_mode));
	ebmc_ext_mem ebmc_ext_mem_i (.pclk(pclk), .pins(pins), .low_data_lines_i(low_data_lines_i));
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic close_out;
		$display("Checks %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : close_out
	task automatic hang(input logic ok);
		if (!ok) begin
			fails++;
			close_out();
		end
	endtask : hang
	// APB transfer; reads leave their expectation in the queue
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] exp);
		if (!w) notes.push_back({1'b1, exp});
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		hang(pready === 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// CPU read: kind 0 internal, 1 external, 2 refused
	task automatic cpu(input logic [23:0] a, input int kind);
		rnd = lfsr(rnd);
		notes.push_back(kind == 2 ? 34'h100000000 : {2'h2, 16'h0, kind == 0 ? rnd : {8'h0, a[7:0] ^ 8'h5A}});
		@(posedge pclk);
		int_rdata <= rnd;
		cpu_req <= '{addr: a, wr: 1'b0, wdata: rnd};
		cpu_req_valid <= 1'b1;
		seen_int = 3'h0;
		seen_rd = 1'b0;
		seen_ale = 1'b0;
		seen_a2 = 1'b0;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (cpu_req_ready !== 1'b1 && n < 20);
		cpu_req_valid <= 1'b0;
		do begin
			@(posedge pclk);
			n++;
			seen_int |= int_sel;
			seen_rd |= !pins.rd_n;
			seen_ale |= pins.ale;
			seen_a2 |= !pins.area_two_n;
		end while (cpu_done !== 1'b1 && n < 60);
		hang(cpu_done === 1'b1);
	endtask : cpu
	task automatic take(input logic [33:0] got);
		chk(got, notes.size() > 0 ? notes.pop_front() : '1);
	endtask : take
	// Watch results as they appear and compare with the oldest note
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite) take({1'b1, pslverr, prdata});
		if (cpu_done === 1'b1) take({notes[0][33], cpu_fault, notes[0][33] ? {16'h0, cpu_rdata} : 32'h0});
	end
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	initial begin
		{psel, penable, pwrite, cpu_req_valid, mode_select_pin, presetn} = 6'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		int_rdata = 16'h0;
		cpu_req = '0;
		rnd = 16'h0042;
		fails = 0;
		total_checks = 0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, 12'h244, 0, 33'h0);
		apb(0, 12'h178, 0, 33'h0);
		chk(port_bus_mode, 1'b0);
		cpu(24'h000100, 0);
		chk(seen_int, 3'h2);
		cpu(24'h200010, 2);
		chk(seen_rd, 1'b0);
		apb(0, 12'h300, 0, 33'h100000000);
		$display("reset and single-chip test done");
		for (int m = 3; m > 0; m--) begin
			apb(1, 12'h178, 32'(m), 0);
			apb(0, 12'h244, 0, 33'(m));
			chk(port_bus_mode, m != 3);
			cpu(24'h009000, int'(m == 2));
			chk(seen_int, m == 2 ? 3'h0 : 3'h4);
		end
		$display("mode code test done");
		cpu(24'h000200, 0);
		chk(seen_rd, 1'b0);
		cpu(24'h200034, 1);
		chk(pins.addr, 24'h200034);
		chk(seen_a2, 1'b1);
		apb(1, 12'h18C, 32'h10, 0);
		cpu(24'h000300, 0);
		chk(pins.addr, 24'h200034);
		cpu(24'h2000C1, 1);
		chk(pins.addr, 24'h2000C1);
		apb(1, 12'h18C, 0, 0);
		$display("address output test done");
		apb(1, 12'h240, 1, 0);
		apb(1, 12'h214, 32'h20, 0);
		cpu(24'h2000A7, 1);
		chk(seen_ale, 1'b1);
		cpu(24'h100055, 1);
		chk(seen_ale, 1'b0);
		chk(seen_a2, 1'b0);
		$display("multiplexed bus test done");
		mode_select_pin <= 1'b1;
		repeat (8) @(posedge pclk);
		apb(1, 12'h178, 0, 0);
		apb(0, 12'h244, 0, 33'h6);
		apb(0, 12'h178, 0, 33'h2);
		$display("strap test done");
		close_out();
	end
endmodule : testbench
